// file: hdl/fsqc_host.sv
// Purpose: Wishbone-controlled host that drives a parallel flash's strobes.
// Assumes: Flash word addressed, 32-bit data; classic Wishbone slave, 32 bits.
// Notes: Sequences query, reset, secured-region enter/exit and program.
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`include "fsqc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fsqc_host
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [31:0] i_flash_dq,
  output logic [31:0] o_flash_dq,
  output logic o_flash_dq_oe,
  output logic [23:0] o_flash_addr,
  output logic o_flash_ce_n,
  output logic o_flash_oe_n,
  output logic o_flash_we_n
);
  typedef enum logic [3:0] {
    FSQC_S_IDLE = 4'h1,
    FSQC_S_ISSUE = 4'h2,
    FSQC_S_WAIT = 4'h4,
    FSQC_S_BOOT = 4'h8
  } fsqc_seq_state_t;

  localparam logic [23:0] QRY_SIG = `FSQC_QRY_SIG;

  // Check a query read: byte in both low lanes, upper half zero
  function automatic logic qry_byte_ok(input logic [31:0] d, input logic [7:0] b);
    qry_byte_ok = (d == {16'h0000, b, b});
  endfunction : qry_byte_ok

  fsqc_seq_state_t seq_reg, seq_next;
  logic [4:0] ctrl_reg, ctrl_next;
  logic [23:0] addr_reg, addr_next;
  logic [31:0] data_reg, data_next;
  logic [1:0] step_reg, step_next;
  logic [1:0] last_next;
  logic query_reg, query_next;
  logic qry_ok_reg, qry_ok_next;
  logic inhibit_reg, inhibit_next;
  logic ack_reg, ack_next;
  logic [31:0] wb_dat_reg, wb_dat_next;
  logic start;
  logic write;
  fsqc_pkg::fsqc_cyc_t cyc;
  fsqc_pkg::fsqc_pins_t pins;
  logic [31:0] rdata;
  logic done;
  logic wb_req;
  logic [2:0] op;

  assign wb_req = i_wb_cyc && i_wb_stb && !ack_reg;
  assign op = ctrl_reg[`FSQC_CTRL_OP_MSB:`FSQC_CTRL_OP_LSB];

  // Cycle table of the chosen sequence, step by step
  always_comb
  begin
    cyc = '{addr: addr_reg, data: data_reg};
    write = 1'b1;
    last_next = 2'h0;
    unique case (op)
      `FSQC_OP_READ:
        write = 1'b0;
      `FSQC_OP_WRITE:
        last_next = 2'h0;
      `FSQC_OP_QUERY:
        cyc = '{addr: `FSQC_QUERY_ADDR, data: `FSQC_QUERY_CMD};
      `FSQC_OP_RESET:
        cyc = '{addr: addr_reg, data: `FSQC_RESET_CMD};
      `FSQC_OP_SEC_ENTER, `FSQC_OP_SEC_EXIT, `FSQC_OP_PROGRAM:
      begin
        last_next = (op == `FSQC_OP_SEC_EXIT) ? 2'h3 : 2'h2;
        if (step_reg == 2'h0)
          cyc = '{addr: `FSQC_UNLOCK1_ADDR, data: `FSQC_UNLOCK1_DATA};
        else if (step_reg == 2'h1)
          cyc = '{addr: `FSQC_UNLOCK2_ADDR, data: `FSQC_UNLOCK2_DATA};
        else if (step_reg == 2'h2)
          cyc = '{addr: `FSQC_UNLOCK1_ADDR,
                  data: (op == `FSQC_OP_SEC_ENTER) ? `FSQC_SEC_ENTER_CMD :
                        (op == `FSQC_OP_SEC_EXIT) ? `FSQC_SEC_EXIT_CMD :
                        `FSQC_PROG_CMD};
        else if (op == `FSQC_OP_SEC_EXIT)
          cyc = '{addr: addr_reg, data: `FSQC_SEC_EXIT2_CMD};
        else
          cyc = '{addr: addr_reg, data: data_reg};
        if (op == `FSQC_OP_PROGRAM)
          last_next = 2'h3;
      end
      default:
        write = 1'b0;
    endcase
  end

  always_comb
  begin
    seq_next = seq_reg;
    ctrl_next = ctrl_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    step_next = step_reg;
    query_next = query_reg;
    qry_ok_next = qry_ok_reg;
    inhibit_next = !ctrl_reg[`FSQC_CTRL_SUPPLY_OK];
    ack_next = 1'b0;
    wb_dat_next = wb_dat_reg;
    start = 1'b0;
    if (wb_req)
    begin
      ack_next = 1'b1;
      unique case (i_wb_adr)
        `FSQC_REG_CTRL: wb_dat_next = {27'h0000000, ctrl_reg};
        `FSQC_REG_ADDR: wb_dat_next = {8'h00, addr_reg};
        `FSQC_REG_DATA: wb_dat_next = data_reg;
        `FSQC_REG_STAT: wb_dat_next = {28'h0000000, query_reg, inhibit_reg, qry_ok_reg,
                                      seq_reg != FSQC_S_IDLE};
        default: wb_dat_next = 32'h00000000;
      endcase
      if (i_wb_we && seq_reg == FSQC_S_IDLE)
      begin
        if (i_wb_adr == `FSQC_REG_CTRL && i_wb_sel[0])
          ctrl_next = i_wb_dat[4:0];
        if (i_wb_adr == `FSQC_REG_ADDR)
          addr_next = i_wb_dat[23:0];
        if (i_wb_adr == `FSQC_REG_DATA)
          data_next = i_wb_dat;
      end
    end
    unique case (seq_reg)
      FSQC_S_BOOT:
        seq_next = FSQC_S_IDLE;
      FSQC_S_IDLE:
      begin
        step_next = 2'h0;
        // No write is issued while the supply is reported low
        if (ctrl_reg[`FSQC_CTRL_GO] && (!write || ctrl_reg[`FSQC_CTRL_SUPPLY_OK]))
          seq_next = FSQC_S_ISSUE;
        else if (ctrl_reg[`FSQC_CTRL_GO])
          // Only a refused order is dropped, so a fresh software write of GO survives
          ctrl_next[`FSQC_CTRL_GO] = 1'b0;
      end
      FSQC_S_ISSUE:
      begin
        start = 1'b1;
        seq_next = FSQC_S_WAIT;
      end
      FSQC_S_WAIT:
        if (done)
        begin
          if (step_reg == last_next)
          begin
            ctrl_next[`FSQC_CTRL_GO] = 1'b0;
            seq_next = FSQC_S_IDLE;
            if (op == `FSQC_OP_QUERY)
              query_next = 1'b1;
            if (op == `FSQC_OP_RESET)
              query_next = 1'b0;
            if (!write)
            begin
              data_next = rdata;
              if (query_reg && addr_reg == `FSQC_QRY_ADDR_Q)
                qry_ok_next = qry_byte_ok(rdata, QRY_SIG[23:16]);
            end
          end
          else
          begin
            step_next = step_reg + 2'h1;
            seq_next = FSQC_S_ISSUE;
          end
        end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      seq_reg <= FSQC_S_BOOT;
      ctrl_reg <= `FSQC_CTRL_RESET;
      addr_reg <= 24'h000000;
      data_reg <= 32'h00000000;
      step_reg <= 2'h0;
      query_reg <= 1'b0;
      qry_ok_reg <= 1'b0;
      inhibit_reg <= 1'b1;
      ack_reg <= 1'b0;
      wb_dat_reg <= 32'h00000000;
    end
    else
    begin
      seq_reg <= seq_next;
      ctrl_reg <= ctrl_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      step_reg <= step_next;
      query_reg <= query_next;
      qry_ok_reg <= qry_ok_next;
      inhibit_reg <= inhibit_next;
      ack_reg <= ack_next;
      wb_dat_reg <= wb_dat_next;
    end
  end

  fsqc_bus_cycle u_cycle
  (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_start(start),
    .i_write(write),
    .i_cyc(cyc),
    .i_dq_in(i_flash_dq),
    .o_pins(pins),
    .o_rdata(rdata),
    .o_done(done)
  );

  // Pins come straight from the cycle engine's flip-flops
  assign o_flash_dq = pins.dq_out;
  assign o_flash_dq_oe = pins.dq_oe;
  assign o_flash_addr = pins.addr;
  assign o_flash_ce_n = pins.ce_n;
  assign o_flash_oe_n = pins.oe_n;
  assign o_flash_we_n = pins.we_n;
  assign o_wb_ack = ack_reg;
  assign o_wb_dat = wb_dat_reg;

  power_up_idle_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    seq_reg == FSQC_S_BOOT |-> o_flash_we_n && o_flash_ce_n)
    else $error("strobe active during boot");
  supply_lock_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(o_flash_we_n) |-> ctrl_reg[`FSQC_CTRL_SUPPLY_OK])
    else $error("write issued with supply low");
  // Checked on the pins, not on the table that feeds them
  unlock_first_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(o_flash_we_n) && (op == `FSQC_OP_PROGRAM) && step_reg == 2'h0
    |-> o_flash_addr == `FSQC_UNLOCK1_ADDR && o_flash_dq == `FSQC_UNLOCK1_DATA)
    else $error("program did not open with unlock");
  query_cmd_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(o_flash_we_n) && op == `FSQC_OP_QUERY |-> o_flash_addr == `FSQC_QUERY_ADDR
    && o_flash_dq == `FSQC_QUERY_CMD)
    else $error("query command malformed");
  query_exit_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(query_reg) |-> $past(op) == `FSQC_OP_RESET)
    else $error("query mode left without reset");
  ack_pulse_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held two cycles");
  cover_query_c: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(query_reg));
  cover_prog_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    done && op == `FSQC_OP_PROGRAM && step_reg == 2'h3);
  cover_sig_c: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(qry_ok_reg));
endmodule : fsqc_host
`default_nettype wire

// file: hdl/fsqc_defines.svh
// Purpose: Constants for the flash query/secured-region host controller.
// Assumes: 40 MHz clock; flash data bus 32 bits wide, word addressed.
// Notes: Timing figures in ns, cycle counts derived from them.
`ifndef FSQC_DEFINES_SVH
`define FSQC_DEFINES_SVH
`define FSQC_CLK_PERIOD_NS 25
`define FSQC_SETUP_NS 50
`define FSQC_PULSE_NS 50
`define FSQC_READ_NS 100
`define FSQC_SETUP_CYC ((`FSQC_SETUP_NS + `FSQC_CLK_PERIOD_NS - 1) / `FSQC_CLK_PERIOD_NS)
`define FSQC_PULSE_CYC ((`FSQC_PULSE_NS + `FSQC_CLK_PERIOD_NS - 1) / `FSQC_CLK_PERIOD_NS)
`define FSQC_READ_CYC ((`FSQC_READ_NS + `FSQC_CLK_PERIOD_NS - 1) / `FSQC_CLK_PERIOD_NS)
// Register word offsets (byte address)
`define FSQC_REG_CTRL 4'h0
`define FSQC_REG_ADDR 4'h4
`define FSQC_REG_DATA 4'h8
`define FSQC_REG_STAT 4'hC
// Control fields
`define FSQC_CTRL_GO 0
`define FSQC_CTRL_OP_LSB 1
`define FSQC_CTRL_OP_MSB 3
`define FSQC_CTRL_SUPPLY_OK 4
`define FSQC_CTRL_RESET 5'h00
// Status fields
`define FSQC_STAT_BUSY 0
`define FSQC_STAT_QRY_OK 1
`define FSQC_STAT_INHIBIT 2
`define FSQC_STAT_QUERY_MODE 3
// Operation codes
`define FSQC_OP_READ 3'h0
`define FSQC_OP_WRITE 3'h1
`define FSQC_OP_QUERY 3'h2
`define FSQC_OP_RESET 3'h3
`define FSQC_OP_SEC_ENTER 3'h4
`define FSQC_OP_SEC_EXIT 3'h5
`define FSQC_OP_PROGRAM 3'h6
// Flash command addresses and data
`define FSQC_QUERY_ADDR 24'h000055
`define FSQC_QUERY_CMD 32'h00000098
`define FSQC_RESET_CMD 32'h000000F0
`define FSQC_UNLOCK1_ADDR 24'h000555
`define FSQC_UNLOCK1_DATA 32'h000000AA
`define FSQC_UNLOCK2_ADDR 24'h0002AA
`define FSQC_UNLOCK2_DATA 32'h00000055
`define FSQC_SEC_ENTER_CMD 32'h00000088
`define FSQC_SEC_EXIT_CMD 32'h00000090
`define FSQC_SEC_EXIT2_CMD 32'h00000000
`define FSQC_PROG_CMD 32'h000000A0
`define FSQC_QRY_ADDR_Q 24'h000010
`define FSQC_QRY_SIG 24'h515259
`endif

// file: hdl/fsqc_pkg.sv
// Purpose: Types shared by the flash host controller files.
// Assumes: Constants come from fsqc_defines.svh.
// Notes: Pin group travels as one packed struct.
package fsqc_pkg;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [23:0] addr;
    logic [31:0] dq_out;
    logic dq_oe;
  } fsqc_pins_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [31:0] data;
  } fsqc_cyc_t;

  typedef enum logic [4:0] {
    FSQC_IDLE = 5'h01,
    FSQC_SETUP = 5'h02,
    FSQC_PULSE = 5'h04,
    FSQC_HOLD = 5'h08,
    FSQC_DONE = 5'h10
  } fsqc_bus_state_t;
endpackage : fsqc_pkg

// file: hdl/fsqc_bus_cycle.sv
// Purpose: Runs one flash write or read strobe cycle on the pins.
// Assumes: Inputs synchronous to i_clk; flash is strobe driven with no clock.
// Notes: Strobes are always driven as full multi-cycle pulses, never glitches.
`include "fsqc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fsqc_bus_cycle
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic i_write,
  input wire fsqc_pkg::fsqc_cyc_t i_cyc,
  input wire logic [31:0] i_dq_in,
  output var fsqc_pkg::fsqc_pins_t o_pins,
  output logic [31:0] o_rdata,
  output logic o_done
);
  fsqc_pkg::fsqc_bus_state_t state_reg, state_next;
  fsqc_pkg::fsqc_pins_t pins_reg, pins_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [3:0] cnt_reg, cnt_next;
  logic write_reg, write_next;

  always_comb
  begin
    state_next = state_reg;
    pins_next = pins_reg;
    rdata_next = rdata_reg;
    cnt_next = cnt_reg;
    write_next = write_reg;
    unique case (state_reg)
      fsqc_pkg::FSQC_IDLE:
      begin
        if (i_start)
        begin
          // Address and data settle with every strobe high
          pins_next.addr = i_cyc.addr;
          pins_next.dq_out = i_cyc.data;
          pins_next.dq_oe = i_write;
          write_next = i_write;
          cnt_next = 4'(`FSQC_SETUP_CYC);
          state_next = fsqc_pkg::FSQC_SETUP;
        end
      end
      fsqc_pkg::FSQC_SETUP:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1)
        begin
          // Write: CE and WE low, OE held high; read: CE and OE low, WE high
          pins_next.ce_n = 1'b0;
          pins_next.we_n = !write_reg;
          pins_next.oe_n = write_reg;
          cnt_next = write_reg ? 4'(`FSQC_PULSE_CYC) : 4'(`FSQC_READ_CYC);
          state_next = fsqc_pkg::FSQC_PULSE;
        end
      end
      fsqc_pkg::FSQC_PULSE:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1)
        begin
          if (!write_reg)
            rdata_next = i_dq_in;
          pins_next.ce_n = 1'b1;
          pins_next.we_n = 1'b1;
          pins_next.oe_n = 1'b1;
          cnt_next = 4'(`FSQC_SETUP_CYC);
          state_next = fsqc_pkg::FSQC_HOLD;
        end
      end
      fsqc_pkg::FSQC_HOLD:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1)
        begin
          pins_next.dq_oe = 1'b0;
          state_next = fsqc_pkg::FSQC_DONE;
        end
      end
      fsqc_pkg::FSQC_DONE:
        state_next = fsqc_pkg::FSQC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_reg <= fsqc_pkg::FSQC_IDLE;
      pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 24'h000000,
                    dq_out: 32'h00000000, dq_oe: 1'b0};
      rdata_reg <= 32'h00000000;
      cnt_reg <= 4'h0;
      write_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pins_reg <= pins_next;
      rdata_reg <= rdata_next;
      cnt_reg <= cnt_next;
      write_reg <= write_next;
    end
  end

  assign o_pins = pins_reg;
  assign o_rdata = rdata_reg;
  assign o_done = (state_reg == fsqc_pkg::FSQC_DONE);

  // Write strobe never low together with output enable low
  logical_inhibit_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !pins_reg.we_n |-> (!pins_reg.ce_n && pins_reg.oe_n))
    else $error("write strobe low while read enabled");
  // Write pulse lasts at least two cycles (50 ns)
  pulse_width_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(pins_reg.we_n) |-> !pins_reg.we_n[*2])
    else $error("write pulse shorter than minimum");
  cover_write_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(pins_reg.we_n));
  cover_read_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(pins_reg.oe_n));
endmodule : fsqc_bus_cycle
`default_nettype wire

// file: test/fsqc_flash_model.sv
// Purpose: Behavioural parallel flash that answers the host's strobes.
// Assumes: 32-bit word-addressed part with a factory-locked secured region.
// Notes: Only the query, reset, secured-region and program paths are modelled.
`timescale 1ns/1ps
`default_nettype none
module fsqc_flash_model
#(
  parameter logic [7:0] OEM_SET = 8'h3C, // Arbitrary command-set code
  parameter logic [31:0] SERIAL = 32'h6B000000
)
(
  input wire logic i_vcc_ok,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [23:0] i_addr,
  input wire logic [31:0] i_dq,
  output logic [31:0] o_dq,
  output logic o_fault
);
  logic [31:0] arr [int];
  logic [31:0] cur = 32'h0;
  logic [31:0] last = 32'h0;
  logic [23:0] wa;
  logic armed = 1'b0;
  logic qry = 1'b0;
  logic sec = 1'b0;
  int st = 0;
  realtime t0;

  function automatic logic [7:0] qbyte(input logic [23:0] a);
    case (a)
      24'h10: return 8'h51;
      24'h11: return 8'h52;
      24'h12: return 8'h59;
      24'h13: return OEM_SET;
      24'h15: return 8'h40;
      24'h1F, 24'h20: return 8'h07;
      24'h21: return 8'h0A;
      24'h23, 24'h28, 24'h2C, 24'h30: return 8'h01;
      24'h24, 24'h2A: return 8'h05;
      24'h25: return 8'h04;
      24'h27: return 8'h17;
      24'h2D: return 8'h7F;
      default: return 8'h00;
    endcase
  endfunction : qbyte

  function automatic logic [31:0] look(input logic [23:0] a);
    if (qry)
      return {16'h0000, qbyte(a), qbyte(a)};
    if (sec)
      return (a < 24'h8) ? SERIAL + {8'h00, a} : 32'hFFFFFFFF;
    return arr.exists(a) ? arr[a] : 32'hFFFFFFFF;
  endfunction : look

  task automatic take(input logic [23:0] a, input logic [31:0] d);
    logic [7:0] c;
    c = d[7:0];
    if (st == 4)
    begin
      if (!sec)
        arr[a] = d;
      st = 0;
    end
    else if (c == 8'hF0)
    begin
      // Leaving query returns to the mode it was entered from
      if (!qry)
        st = 0;
      qry = 1'b0;
    end
    else if ((st == 0 || st == 3) && a == 24'h55 && c == 8'h98)
      qry = 1'b1;
    else if (st == 0 && a == 24'h555 && c == 8'hAA)
      st = 1;
    else if (st == 1 && a == 24'h2AA && c == 8'h55)
      st = 2;
    else if (st == 2 && c == 8'h88)
    begin
      sec = 1'b1;
      st = 0;
    end
    else if (st == 2)
      st = (c == 8'hA0) ? 4 : (c == 8'h90) ? 3 : 0;
    else
    begin
      if (st == 3 && c == 8'h00)
        sec = 1'b0;
      st = 0;
    end
  endtask : take

  // Strobes move on one host edge together, so look just after the fall
  always @(negedge i_we_n)
  begin
    t0 = $realtime;
    #1;
    armed = !i_ce_n && i_oe_n && i_vcc_ok;
    wa = i_addr;
  end

  always @(posedge i_we_n)
    if (armed && i_vcc_ok && ($realtime - t0) >= 5.0)
      take(wa, i_dq);

  always @(negedge i_vcc_ok)
    {qry, sec} = 2'b00;

  always @(negedge i_oe_n)
  begin
    #1;
    cur = look(i_addr);
  end

  always @(posedge i_oe_n)
    last = cur;

  initial
    o_fault = 1'b0;

  always @(negedge i_we_n or negedge i_oe_n)
    if (!i_we_n && !i_oe_n)
      o_fault = 1'b1;

  // A released bus shows the inverse of its last value, never a stale copy
  assign o_dq = (!i_ce_n && !i_oe_n) ? cur : ~last;
endmodule : fsqc_flash_model
`default_nettype wire

// file: test/fsqc_host_test.sv
// Purpose: Self-checking bench for the flash host controller.
// Assumes: Flash model on the shared data bus, factory-locked region.
// Notes: Query table rows first, then sequences, refusals and reset.
`include "fsqc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fsqc_host_test;
  localparam logic [31:0] SER = 32'h6B000000;
  localparam logic [15:0] QT [27] = '{16'h1051, 16'h1152, 16'h1259, 16'h1540, 16'h1600,
    16'h1700, 16'h1A00, 16'h1F07, 16'h2007, 16'h210A, 16'h2200, 16'h2301, 16'h2405,
    16'h2504, 16'h2600, 16'h2717, 16'h2801, 16'h2900, 16'h2A05, 16'h2B00, 16'h2C01,
    16'h2D7F, 16'h2E00, 16'h2F00, 16'h3001, 16'h3100, 16'h3C00};
  logic clk, arst_n, cyc, stb, we, ack, hoe, ce_n, oe_n, we_n, fault;
  logic [3:0] adr;
  logic [31:0] wdat, rdat, hdq, mdq, dq, q;
  logic [23:0] faddr;
  int errors = 0;
  int compares = 0;

  assign dq = hoe ? hdq : mdq;

  fsqc_host i_fsqc_host
  (
    .i_clk(clk), .i_arst_n(arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_flash_dq(dq), .o_flash_dq(hdq), .o_flash_dq_oe(hoe), .o_flash_addr(faddr),
    .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n), .o_flash_we_n(we_n)
  );

  fsqc_flash_model #(.SERIAL(SER)) i_fsqc_flash_model
  (
    .i_vcc_ok(1'b1), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(faddr),
    .i_dq(dq), .o_dq(mdq), .o_fault(fault)
  );

  task automatic close_out;
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
    begin
      errors++;
      close_out();
    end
  endtask : wb

  task automatic op(input logic [2:0] o, input logic [23:0] a, input logic [31:0] d,
    input logic s);
    logic [31:0] r;
    int n;
    n = 0;
    wb(1'b1, `FSQC_REG_ADDR, {8'h00, a}, r);
    wb(1'b1, `FSQC_REG_DATA, d, r);
    wb(1'b1, `FSQC_REG_CTRL, {27'h0, s, o, 1'b1}, r);
    do
    begin
      wb(1'b0, `FSQC_REG_CTRL, 32'h0, r);
      n++;
    end
    while (r[0] !== 1'b0 && n < 100);
    if (n >= 100)
      chk("go done", 32'h0, r);
  endtask : op

  task automatic rd(input logic [23:0] a, output logic [31:0] r);
    op(`FSQC_OP_READ, a, 32'h0, 1'b1);
    wb(1'b0, `FSQC_REG_DATA, 32'h0, r);
  endtask : rd

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Whole run needs about 1150 cycles; allow generous slack for slow polls
  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    close_out();
  end

  initial
  begin
    {arst_n, cyc, stb, we, adr, wdat} = '0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    op(`FSQC_OP_QUERY, `FSQC_QUERY_ADDR, 32'h0, 1'b1);
    foreach (QT[i])
    begin
      rd({16'h0000, QT[i][15:8]}, q);
      chk("query word", {16'h0000, QT[i][7:0], QT[i][7:0]}, q);
    end
    rd(`FSQC_QRY_ADDR_Q, q);
    wb(1'b0, `FSQC_REG_STAT, 32'h0, q);
    chk("status", 32'hA, q & 32'hF);
    op(`FSQC_OP_RESET, 24'h0, 32'h0, 1'b1);
    op(`FSQC_OP_PROGRAM, 24'h100, 32'hA5A55A5A, 1'b1);
    op(`FSQC_OP_WRITE, 24'h100, 32'h0, 1'b1);
    rd(24'h100, q);
    chk("array word", 32'hA5A55A5A, q);
    wb(1'b0, `FSQC_REG_STAT, 32'h0, q);
    chk("status", 32'h2, q & 32'hF);
    op(`FSQC_OP_SEC_ENTER, 24'h0, 32'h0, 1'b1);
    op(`FSQC_OP_PROGRAM, 24'h3, 32'h0, 1'b1);
    op(`FSQC_OP_PROGRAM, 24'h20, 32'h0, 1'b1);
    rd(24'h3, q);
    chk("serial word", SER + 32'h3, q);
    rd(24'h20, q);
    chk("secured word", 32'hFFFFFFFF, q);
    op(`FSQC_OP_SEC_EXIT, 24'h0, 32'h0, 1'b1);
    rd(24'h3, q);
    chk("array word", 32'hFFFFFFFF, q);
    op(`FSQC_OP_PROGRAM, 24'h200, 32'h0, 1'b0);
    wb(1'b0, `FSQC_REG_STAT, 32'h0, q);
    chk("status", 32'h6, q & 32'hF);
    rd(24'h200, q);
    chk("array word", 32'hFFFFFFFF, q);
    wb(1'b0, 4'h1, 32'h0, q);
    chk("unmapped", 32'h0, q);
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk("idle strobes", 32'h7, {29'h0, ce_n, oe_n, we_n});
    chk("reset outputs", 32'h0, {30'h0, ack, hoe});
    @(posedge clk);
    arst_n <= 1'b1;
    rd(24'h100, q);
    chk("array word", 32'hA5A55A5A, q);
    chk("strobe overlap", 32'h0, {31'h0, fault});
    close_out();
  end
endmodule : fsqc_host_test
`default_nettype wire
